// ===== pkg/ppg_map.svh
// register offsets, field positions, reset values of the pulse block
`ifndef PPG_MAP_SVH
`define PPG_MAP_SVH
// word indices; byte offset is index times four
`define PPG_IDX_CTRL      4'h0
`define PPG_IDX_PERIOD    4'h1
`define PPG_IDX_PRESCALE  4'h2
`define PPG_IDX_STATUS    4'h3
// control word fields
`define PPG_CTRL_PSEN     0
`define PPG_CTRL_SYNC_LSB 1
`define PPG_CTRL_SRC      3
`define PPG_CTRL_PIN_LSB  4
`define PPG_CTRL_GSYNC    8
`define PPG_CTRL_MASK     32'h0000007F
// channel config fields
`define PPG_CFG_FUNC_LSB  0
`define PPG_CFG_INV       2
`define PPG_CFG_EN        3
`define PPG_CFG_LVL       4
`define PPG_CFG_LEAD_LSB  5
`define PPG_CFG_TRAIL_LSB 7
`define PPG_CFG_LBEN      9
`define PPG_CFG_LBCH_LSB  10
`define PPG_CFG_LBTYP     13
`define PPG_CFG_TBEN      14
`define PPG_CFG_TBCH_LSB  15
`define PPG_CFG_TBTYP     18
`define PPG_CFG_MASK      32'h0007FFFF
// reset values and bus response codes
`define PPG_PERIOD_RST    16'h018F
`define PPG_PRESCALE_RST  16'h0000
`define PPG_RESP_OKAY     2'h0
`define PPG_RESP_SLVERR   2'h2
`endif

// ===== pkg/ppg_pkg.sv
// types of the pulse block
package ppg_pkg;
    typedef enum logic [1:0] {
        funcStatic        = 2'h0,
        funcPulseWidth    = 2'h1,
        pulsePositionMode = 2'h2,
        funcReserved      = 2'h3
    } ppg_func_t;
    typedef enum logic [1:0] {
        syncOff          = 2'h0,
        syncOnRising     = 2'h1,
        syncOnFalling    = 2'h2,
        syncOnBothEdges  = 2'h3
    } ppg_sync_t;
    typedef enum logic {
        bindToLeadingEdge  = 1'h0,
        bindToTrailingEdge = 1'h1
    } ppg_bind_t;
endpackage

// ===== pkg/ppg_tb_if.sv
// period counter carrier between timebase and channels
`timescale 1ns/10ps
`default_nettype none
interface ppg_tb_if #(
    parameter int CW = 16
);
    logic [CW-1:0] cnt;
    logic          step;
    modport src  (output cnt, output step);
    modport chan (input cnt, input step);
endinterface
`default_nettype wire

// ===== hdl/ppg_timebase.sv
// prescaler, period counter and sync edge detector
`timescale 1ns/10ps
`default_nettype none
module ppg_timebase #(
    parameter int CW = 16,
    parameter int PW = 16
) (
    input  wire logic              mclk,        // clock
    input  wire logic              rst_n,       // async reset
    input  wire logic              prescaleEn,  // use prescaled timebase
    input  wire logic [PW-1:0]     prescaleDiv, // divide minus one
    input  wire logic [CW-1:0]     period,      // terminal count
    input  wire logic              syncLevel,   // synchronised sync source
    input  wire ppg_pkg::ppg_sync_t syncMode,   // sync edge select
    ppg_tb_if.src                  tb           // counter out
);
    logic [PW-1:0] psCnt_r;
    logic [CW-1:0] cnt_r;
    logic          syncSamp_r;
    logic          step_r;
    wire logic     tickNow;
    wire logic     rise;
    wire logic     fall;
    wire logic     syncHit;
    wire logic     restart;

    assign tickNow = ~prescaleEn | (psCnt_r == prescaleDiv);
    assign rise = syncLevel & ~syncSamp_r;
    assign fall = ~syncLevel & syncSamp_r;
    assign syncHit = tickNow & (((syncMode == ppg_pkg::syncOnRising) & rise)
                   | ((syncMode == ppg_pkg::syncOnFalling) & fall)
                   | ((syncMode == ppg_pkg::syncOnBothEdges) & (rise | fall)));
    assign restart = tickNow & ((cnt_r >= period) | syncHit);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            psCnt_r    <= '0;
            cnt_r      <= '0;
            syncSamp_r <= 1'b0;
            step_r     <= 1'b0;
        end else begin
            psCnt_r <= tickNow ? '0 : psCnt_r + PW'(1);
            step_r  <= tickNow;
            if (tickNow) begin
                syncSamp_r <= syncLevel;
                cnt_r      <= restart ? '0 : cnt_r + CW'(1);
            end
        end
    end

    assign tb.cnt  = cnt_r;
    assign tb.step = step_r;
endmodule
`default_nettype wire

// ===== hdl/ppg_channel.sv
// one pulse channel: compare against counter, polarity, disable level
`timescale 1ns/10ps
`default_nettype none
module ppg_channel #(
    parameter int CW = 16
) (
    input  wire logic              mclk,     // clock
    input  wire logic              rst_n,    // async reset
    input  wire ppg_pkg::ppg_func_t func,    // channel function
    input  wire logic              invert,   // polarity inversion
    input  wire logic              enable,   // pulse enable
    input  wire logic              level,    // static level
    input  wire logic [CW-1:0]     leadCnt,  // leading compare
    input  wire logic [CW-1:0]     trailCnt, // trailing compare
    ppg_tb_if.chan                 tb,       // counter in
    output logic                   pulseOut  // registered output
);
    logic      active_r;
    logic      active_nxt;
    wire logic isPpm;
    wire logic wrap;
    wire logic holdLevel;

    assign isPpm = (func == ppg_pkg::pulsePositionMode);
    assign wrap = leadCnt > trailCnt;
    assign holdLevel = (func == ppg_pkg::funcStatic) | (func == ppg_pkg::funcReserved) | ~enable;

    always_comb begin
        active_nxt = active_r;
        if (tb.step) begin
            if (tb.cnt == '0) begin
                // ppm pulse carried past period end only when wrapping with nonzero trail
                active_nxt = isPpm ? (wrap & active_r & (trailCnt != '0)) : (trailCnt != '0);
            end else if (tb.cnt == trailCnt) begin
                active_nxt = 1'b0;
            end else if (isPpm && tb.cnt == leadCnt) begin
                active_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            pulseOut <= 1'b0;
        end else begin
            active_r <= active_nxt;
            pulseOut <= holdLevel ? level : (active_nxt ^ invert);
        end
    end
endmodule
`default_nettype wire

// ===== hdl/ppg_top.sv
// pulse width and position block with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "ppg_map.svh"
// Contract
// - ppm noninverted: low, high at offset
// - ppm inverted: high, low at offset
// - ppm zero offset becomes one count
// - ppm pulse with zero trail ends at period end
// - offset moves only the leading compare
// - lead after trail wraps into next period
// - one period per block, fractions kept
// - bound edges follow compare value changes
// - lead and trail bind separately
// - disabled channel holds software level
// - re-enable resumes the kept waveform
// - sync from global or pin, edge select
// - sync edge sampled on the timebase
// - sync off frees pin to input
// - pwm starts high, inverted starts low
// - four compare registers, zero to three
// - global sync command pulses all blocks
module ppg_top #(
    parameter int CW  = 16, // period counter width
    parameter int PW  = 16, // prescaler width
    parameter int NCH = 8,  // pulse channels
    parameter int AW  = 8   // axi address width
) (
    input  wire logic           mclk,             // 20 MHz clock
    input  wire logic           rst_n,            // async reset
    input  wire logic [AW-1:0]  awaddr,           // write address
    input  wire logic           awvalid,          // write address valid
    output logic                awready,          // write address ready
    input  wire logic [31:0]    wdata,            // write data
    input  wire logic [3:0]     wstrb,            // write byte enables
    input  wire logic           wvalid,           // write data valid
    output logic                wready,           // write data ready
    output logic [1:0]          bresp,            // write response
    output logic                bvalid,           // write response valid
    input  wire logic           bready,           // write response ready
    input  wire logic [AW-1:0]  araddr,           // read address
    input  wire logic           arvalid,          // read address valid
    output logic                arready,          // read address ready
    output logic [31:0]         rdata,            // read data
    output logic [1:0]          rresp,            // read response
    output logic                rvalid,           // read data valid
    input  wire logic           rready,           // read data ready
    input  wire logic           globalSyncIn,     // shared global sync line
    output logic                globalSyncOut,    // global sync pulse
    input  wire logic [NCH-1:0] digInPins,        // input-capable pins
    output logic [NCH-1:0]      syncPinOwned,     // pin used as sync
    output logic [NCH-1:0]      pulseOutChannels  // pulse outputs
);
    // byte-lane merge
    function automatic logic [31:0] applyStrb(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  st
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // {valid, word index}
    function automatic logic [4:0] regSel(input logic [AW-1:0] a);
        return {(a[AW-1:6] == '0), a[5:2]};
    endfunction

    // fraction of the period length to a count
    function automatic logic [CW-1:0] scaleFrac(
        input logic [CW-1:0] per,
        input logic [15:0]   frac
    );
        logic [CW+16:0] prod;
        prod = ({1'b0, per} + (CW+1)'(1)) * frac;
        return prod[CW+15:16];
    endfunction

    // compare index, own or borrowed from a bound channel
    function automatic logic [1:0] pickIdx(
        input logic             bindEn,
        input logic [2:0]       ch,
        input logic             typ,
        input logic [2*NCH-1:0] leads,
        input logic [2*NCH-1:0] trails,
        input logic [1:0]       own
    );
        logic [1:0] res;
        res = own;
        if (bindEn) begin
            res = (typ == ppg_pkg::bindToTrailingEdge) ? trails[{ch, 1'b0} +: 2] : leads[{ch, 1'b0} +: 2];
        end
        return res;
    endfunction

    // config write; static channel keeps its enable bit
    function automatic logic [31:0] cfgMerge(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [3:0]  st
    );
        logic [31:0] res;
        res = applyStrb(old, wd, st) & `PPG_CFG_MASK;
        if (res[`PPG_CFG_FUNC_LSB +: 2] == ppg_pkg::funcStatic) begin
            res[`PPG_CFG_EN] = old[`PPG_CFG_EN];
        end
        return res;
    endfunction

    logic [31:0]    ctrl_r;
    logic [CW-1:0]  period_r;
    logic [PW-1:0]  prescale_r;
    logic [15:0]    match_r [4];
    logic [31:0]    chCfg_r [NCH];
    logic           awGot_r;
    logic           wGot_r;
    logic [AW-1:0]  awAddr_r;
    logic [31:0]    wData_r;
    logic [3:0]     wStrb_r;
    logic           awready_r;
    logic           wready_r;
    logic           bvalid_r;
    logic [1:0]     bresp_r;
    logic           arready_r;
    logic           rvalid_r;
    logic [31:0]    rdata_r;
    logic [1:0]     rresp_r;
    logic           gSyncPulse_r;
    logic [NCH-1:0] pinMeta_r;
    logic [NCH-1:0] pinSync_r;
    logic           gMeta_r;
    logic           gSync_r;
    logic [NCH-1:0] syncOwned_r;

    wire logic           awFire;
    wire logic           wFire;
    wire logic           haveAw;
    wire logic           haveW;
    wire logic           doWrite;
    wire logic           awGot_nxt;
    wire logic           wGot_nxt;
    wire logic           bvalid_nxt;
    wire logic           arFire;
    wire logic           rvalid_nxt;
    wire logic [AW-1:0]  wAddrQ;
    wire logic [31:0]    wDataQ;
    wire logic [3:0]     wStrbQ;
    wire logic [4:0]     wSel;
    wire logic [4:0]     rSel;
    wire logic           wrCtrl;
    wire logic           wrPeriod;
    wire logic           wrPrescale;
    wire logic           wrMatch;
    wire logic           wrChan;
    wire logic [31:0]    statusWord;
    wire logic [31:0]    rdWord;
    wire logic           syncLevel;
    wire logic           syncOn;
    wire logic [2:0]     pinIdx;
    wire logic [NCH-1:0] chOut;
    wire logic [2*NCH-1:0] ownLead;
    wire logic [2*NCH-1:0] ownTrail;
    wire logic [CW-1:0]  matchCnt [4];

    ppg_tb_if #(.CW(CW)) tbBus ();

    // write channel handshakes, address and data in either order
    assign awFire     = awvalid & awready_r;
    assign wFire      = wvalid & wready_r;
    assign haveAw     = awGot_r | awFire;
    assign haveW      = wGot_r | wFire;
    assign doWrite    = haveAw & haveW;
    assign awGot_nxt  = haveAw & ~doWrite;
    assign wGot_nxt   = haveW & ~doWrite;
    assign bvalid_nxt = doWrite | (bvalid_r & ~bready);
    assign wAddrQ     = awGot_r ? awAddr_r : awaddr;
    assign wDataQ     = wGot_r ? wData_r : wdata;
    assign wStrbQ     = wGot_r ? wStrb_r : wstrb;
    assign arFire     = arvalid & arready_r;
    assign rvalid_nxt = arFire | (rvalid_r & ~rready);

    assign wSel       = regSel(wAddrQ);
    assign rSel       = regSel(araddr);
    assign wrCtrl     = doWrite & wSel[4] & (wSel[3:0] == `PPG_IDX_CTRL);
    assign wrPeriod   = doWrite & wSel[4] & (wSel[3:0] == `PPG_IDX_PERIOD);
    assign wrPrescale = doWrite & wSel[4] & (wSel[3:0] == `PPG_IDX_PRESCALE);
    // four compare words at indices 4 to 7
    assign wrMatch    = doWrite & wSel[4] & (wSel[3:2] == 2'h1);
    assign wrChan     = doWrite & wSel[4] & wSel[3];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awGot_r   <= 1'b0;
            wGot_r    <= 1'b0;
            awAddr_r  <= '0;
            wData_r   <= 32'h00000000;
            wStrb_r   <= 4'h0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            bvalid_r  <= 1'b0;
            bresp_r   <= `PPG_RESP_OKAY;
        end else begin
            awGot_r   <= awGot_nxt;
            wGot_r    <= wGot_nxt;
            awready_r <= ~awGot_nxt & ~bvalid_nxt;
            wready_r  <= ~wGot_nxt & ~bvalid_nxt;
            bvalid_r  <= bvalid_nxt;
            if (awFire) begin
                awAddr_r <= awaddr;
            end
            if (wFire) begin
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (doWrite) begin
                bresp_r <= wSel[4] ? `PPG_RESP_OKAY : `PPG_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r       <= 32'h00000000;
            period_r     <= CW'(`PPG_PERIOD_RST);
            prescale_r   <= PW'(`PPG_PRESCALE_RST);
            gSyncPulse_r <= 1'b0;
        end else begin
            gSyncPulse_r <= wrCtrl & wStrbQ[1] & wDataQ[`PPG_CTRL_GSYNC];
            if (wrCtrl) begin
                ctrl_r <= applyStrb(ctrl_r, wDataQ, wStrbQ) & `PPG_CTRL_MASK;
            end
            if (wrPeriod) begin
                period_r <= CW'(applyStrb(32'(period_r), wDataQ, wStrbQ));
            end
            if (wrPrescale) begin
                prescale_r <= PW'(applyStrb(32'(prescale_r), wDataQ, wStrbQ));
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < 4; k++) begin
                match_r[k] <= 16'h0000;
            end
            for (int i = 0; i < NCH; i++) begin
                chCfg_r[i] <= 32'h00000000;
            end
        end else begin
            if (wrMatch) begin
                match_r[wSel[1:0]] <= 16'(applyStrb({16'h0000, match_r[wSel[1:0]]}, wDataQ, wStrbQ));
            end
            if (wrChan) begin
                chCfg_r[wSel[2:0]] <= cfgMerge(chCfg_r[wSel[2:0]], wDataQ, wStrbQ);
            end
        end
    end

    // read path
    assign statusWord = 32'({pinSync_r, chOut, tbBus.cnt});
    assign rdWord = !rSel[4] ? 32'h00000000 :
                    rSel[3] ? chCfg_r[rSel[2:0]] :
                    rSel[2] ? {16'h0000, match_r[rSel[1:0]]} :
                    (rSel[3:0] == `PPG_IDX_CTRL) ? ctrl_r :
                    (rSel[3:0] == `PPG_IDX_PERIOD) ? 32'(period_r) :
                    (rSel[3:0] == `PPG_IDX_PRESCALE) ? 32'(prescale_r) :
                    statusWord;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            arready_r <= 1'b1;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `PPG_RESP_OKAY;
        end else begin
            arready_r <= ~rvalid_nxt;
            rvalid_r  <= rvalid_nxt;
            if (arFire) begin
                rdata_r <= rdWord;
                rresp_r <= rSel[4] ? `PPG_RESP_OKAY : `PPG_RESP_SLVERR;
            end
        end
    end

    // pin and global sync synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_r   <= '0;
            pinSync_r   <= '0;
            gMeta_r     <= 1'b0;
            gSync_r     <= 1'b0;
            syncOwned_r <= '0;
        end else begin
            pinMeta_r   <= digInPins;
            pinSync_r   <= pinMeta_r;
            gMeta_r     <= globalSyncIn;
            gSync_r     <= gMeta_r;
            syncOwned_r <= (syncOn & ctrl_r[`PPG_CTRL_SRC]) ? (NCH'(1) << pinIdx) : '0;
        end
    end

    assign pinIdx    = ctrl_r[`PPG_CTRL_PIN_LSB +: 3];
    assign syncOn    = ctrl_r[`PPG_CTRL_SYNC_LSB +: 2] != ppg_pkg::syncOff;
    assign syncLevel = ctrl_r[`PPG_CTRL_SRC] ? pinSync_r[pinIdx] : gSync_r;

    ppg_timebase #(
        .CW (CW),
        .PW (PW)
    ) uTimebase (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .prescaleEn  (ctrl_r[`PPG_CTRL_PSEN]),
        .prescaleDiv (prescale_r),
        .period      (period_r),
        .syncLevel   (syncLevel),
        .syncMode    (ppg_pkg::ppg_sync_t'(ctrl_r[`PPG_CTRL_SYNC_LSB +: 2])),
        .tb          (tbBus.src)
    );

    // compare points from fractions of the period
    for (genvar k = 0; k < 4; k++) begin : gMatch
        assign matchCnt[k] = scaleFrac(period_r, match_r[k]);
    end

    for (genvar i = 0; i < NCH; i++) begin : gCh
        logic [1:0]    leadSel;
        logic [1:0]    trailSel;
        logic [CW-1:0] leadRaw;
        logic [CW-1:0] leadCnt;
        assign ownLead[2*i +: 2]  = chCfg_r[i][`PPG_CFG_LEAD_LSB +: 2];
        assign ownTrail[2*i +: 2] = chCfg_r[i][`PPG_CFG_TRAIL_LSB +: 2];
        // bound edge shares the compare word
        assign leadSel  = pickIdx(chCfg_r[i][`PPG_CFG_LBEN], chCfg_r[i][`PPG_CFG_LBCH_LSB +: 3],
                                  chCfg_r[i][`PPG_CFG_LBTYP], ownLead, ownTrail, ownLead[2*i +: 2]);
        assign trailSel = pickIdx(chCfg_r[i][`PPG_CFG_TBEN], chCfg_r[i][`PPG_CFG_TBCH_LSB +: 3],
                                  chCfg_r[i][`PPG_CFG_TBTYP], ownLead, ownTrail, ownTrail[2*i +: 2]);
        // offset edits only the leading word
        assign leadRaw  = matchCnt[leadSel];
        // leading edge never at count zero
        assign leadCnt  = (leadRaw == '0) ? CW'(1) : leadRaw;

        ppg_channel #(
            .CW (CW)
        ) uChan (
            .mclk     (mclk),
            .rst_n    (rst_n),
            .func     (ppg_pkg::ppg_func_t'(chCfg_r[i][`PPG_CFG_FUNC_LSB +: 2])),
            .invert   (chCfg_r[i][`PPG_CFG_INV]),
            .enable   (chCfg_r[i][`PPG_CFG_EN]),
            .level    (chCfg_r[i][`PPG_CFG_LVL]),
            .leadCnt  (leadCnt),
            .trailCnt (matchCnt[trailSel]),
            .tb       (tbBus.chan),
            .pulseOut (chOut[i])
        );
    end

    assign awready          = awready_r;
    assign wready           = wready_r;
    assign bvalid           = bvalid_r;
    assign bresp            = bresp_r;
    assign arready          = arready_r;
    assign rvalid           = rvalid_r;
    assign rdata            = rdata_r;
    assign rresp            = rresp_r;
    assign globalSyncOut    = gSyncPulse_r;
    assign syncPinOwned     = syncOwned_r;
    assign pulseOutChannels = chOut;
endmodule
`default_nettype wire

// ===== test/ppg_top_chk.sv
// bus handshake and sync output checks of the pulse block
`timescale 1ns/10ps
`default_nettype none
module ppg_top_chk #(
    parameter int AW  = 8,
    parameter int NCH = 8
) (
    input wire logic           mclk,          // clock
    input wire logic           rst_n,         // reset
    input wire logic           awvalid,       // aw valid
    input wire logic           awready,       // aw ready
    input wire logic           wvalid,        // w valid
    input wire logic           wready,        // w ready
    input wire logic           bvalid,        // b valid
    input wire logic           arvalid,       // ar valid
    input wire logic           arready,       // ar ready
    input wire logic [AW-1:0]  araddr,        // ar addr
    input wire logic           rvalid,        // r valid
    input wire logic           rready,        // r ready
    input wire logic [31:0]    rdata,         // r data
    input wire logic [1:0]     rresp,         // r resp
    input wire logic           globalSyncOut, // sync pulse
    input wire logic [NCH-1:0] syncPinOwned   // sync pin
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_gsync_single: assert property (globalSyncOut |=> !globalSyncOut)
        else $error("sync pulse too long");
    a_pin_onehot: assert property ($onehot0(syncPinOwned))
        else $error("several sync pins");
    a_wr_answer: assert property (awvalid && awready && wvalid && wready |=> bvalid)
        else $error("no write response");
    a_wr_block: assert property (bvalid |-> !awready && !wready)
        else $error("ready during response");
    a_rd_answer: assert property (arvalid && arready |=> rvalid)
        else $error("no read response");
    a_rd_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read answered twice");
    a_rd_block: assert property (rvalid |-> !arready)
        else $error("ar ready during response");
    a_rd_unmapped: assert property (arvalid && arready && araddr >= 8'h40 |=> rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_rd_mapped: assert property (arvalid && arready && araddr < 8'h40 |=> rresp == 2'h0)
        else $error("mapped read refused");
    cover property (globalSyncOut);
    cover property (rvalid && rresp == 2'h2);
    cover property (|syncPinOwned);
endmodule
`default_nettype wire

// ===== test/test_ppg_top.sv
// self-checking bench of the pulse block through its register bus
`timescale 1ns/10ps
`default_nettype none
module test_ppg_top;
    logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, gSync;
    logic        awready, wready, bvalid, arready, rvalid, gsOut;
    logic [7:0]  awaddr, araddr, owned, outs;
    logic [31:0] wdata, rdata, rd, cnt;
    logic [1:0]  bresp, rresp, rsp;
    int          err_total, checks, gsCnt, k;
    int          chTab [11] = '{0, 0, 1, 1, 1, 1, 1, 1, 3, 0, 2};
    int          expTab [11] = '{2, 8, 3, 7, 4, 7, 10, 3, 10, 5, 5};
    logic [31:0] cfgTab [11] = '{32'h9, 32'hD, 32'h8A, 32'h8E, 32'hCA, 32'h2A, 32'h92, 32'h8A, 32'h1B, 32'h89,
                                 32'h44009};
    ppg_top i_dut (.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .globalSyncIn(gSync), .globalSyncOut(gsOut), .digInPins(8'hA5),
        .syncPinOwned(owned), .pulseOutChannels(outs));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) if (gsOut === 1'b1) gsCnt++;
    task chk(input logic [31:0] s, input logic [31:0] e, input string w);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", w, e, s);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        rsp = bresp;
        if (i == 99) begin
            err_total++;
            finish_test;
        end
    endtask
    task rdr(input logic [7:0] a);
        int i;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 99; i++) begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
        if (i == 99) begin
            err_total++;
            finish_test;
        end
    endtask
    // high cycles over one period, after settling
    task hc(input int ch, input int len);
        repeat (2 * len) @(posedge mclk);
        cnt = 32'h0;
        repeat (len) begin
            @(posedge mclk);
            cnt = cnt + 32'(outs[ch]);
        end
    endtask
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, gSync} = 7'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        rdr(8'h04);
        chk(rd, 32'h18F, "period reset");
        rdr(8'h0C);
        chk({24'h0, rd[31:24]}, 32'hA5, "input pins");
        rdr(8'h40);
        chk({rd[29:0], rsp}, 32'h2, "unmapped read");
        wr(8'h40, 32'h1);
        chk({30'h0, rsp}, 32'h2, "unmapped write");
        $display("register test done");
        wr(8'h04, 32'h9);
        chk({30'h0, rsp}, 32'h0, "write okay");
        wr(8'h10, 32'h4000);
        wr(8'h14, 32'h8000);
        for (k = 0; k < 11; k++) begin
            wr(8'h20 + 8'(4 * chTab[k]), cfgTab[k]);
            hc(chTab[k], 10);
            chk(cnt, 32'(expTab[k]), "high count");
        end
        wr(8'h14, 32'h4000);
        hc(2, 10);
        chk(cnt, 32'h2, "bound trail");
        wr(8'h04, 32'h13);
        hc(0, 20);
        chk(cnt, 32'h5, "new period");
        wr(8'h08, 32'h1);
        wr(8'h00, 32'h1);
        hc(0, 40);
        chk(cnt, 32'hA, "prescaled");
        $display("waveform test done");
        wr(8'h00, 32'h3A);
        repeat (2) @(posedge mclk);
        chk({24'h0, owned}, 32'h8, "sync pin");
        wr(8'h00, 32'h38);
        repeat (2) @(posedge mclk);
        chk({24'h0, owned}, 32'h0, "pin freed");
        wr(8'h00, 32'h2);
        gSync <= 1'b1;
        repeat (2) @(posedge mclk);
        rdr(8'h0C);
        chk({16'h0, rd[15:0]}, 32'h0, "sync restart");
        wr(8'h00, 32'h100);
        repeat (4) @(posedge mclk);
        chk(32'(gsCnt), 32'h1, "global pulse");
        $display("sync test done");
        finish_test;
    end
endmodule
bind ppg_top ppg_top_chk #(.AW(AW), .NCH(NCH)) u_chk (.mclk(mclk), .rst_n(rst_n), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .globalSyncOut(globalSyncOut), .syncPinOwned(syncPinOwned));
`default_nettype wire
